// File: dis_dma_index_sync.sv
/*
  Six-channel DMA index, sync event and interrupt routing block with
  an APB register slave. Assumes sync events and serial port
  interrupts come from logic on clk; resetn is asynchronous.
*/
`timescale 1ns/1ps
`include "dis_map.svh"
// Behaviour
// R01: source and destination each pick their own element/frame index pair
// R02: mid-frame transfers add the chosen element index to the address
// R03: last transfer of a frame adds the chosen frame index instead
// R04: autobuffer interrupts at full, or half and full when mode bit set
// R05: multiframe, mode bit clear: interrupt only when block completes
// R06: multiframe, mode bit set: interrupt every frame end and block end
// R07: interrupt enable clear suppresses all channel interrupts
// R08: sync code 0 free-runs; 1 to 6 pick serial port events
// R09: sync codes 7 to 12 pick the A-bis serial events
// R10: code 13 timer, 14 external interrupt 3, 15 reserved
// R11: each of six channels has an interrupt; 0-3 share serial lines
// R12: routing select resets to 00, shared lines carry serial interrupts
// R13: 01 routes channels 2,3; 10 routes channels 0 to 3
// R14: element counter decrements per transfer and marks the frame end
// R15: 8-bit frame counter decrements at frame end; zero means one frame
// R16: reserved routing code keeps the shared lines on serial sources
module dis_dma_index_sync #(
  parameter int AW = 16
) (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic                       irq,
  input  wire logic [13:0]           syncEvents,
  input  wire dis_pkg::dis_port_irq_t serialIrq,
  output dis_pkg::dis_port_irq_t     cpuIrqShared,
  output logic [1:0]                 cpuIrqChan45
);

  localparam int NCH = `DIS_CH_COUNT;

  // reset release through two flip-flops
  logic [1:0] rstPipe;
  wire        rstn = rstPipe[1];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rstPipe <= 2'b00;
    else rstPipe <= {rstPipe[0], 1'b1};
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // global registers
  logic [15:0]    prio;
  logic [AW-1:0]  elemIdx0;
  logic [AW-1:0]  elemIdx1;
  logic [AW-1:0]  frmIdx0;
  logic [AW-1:0]  frmIdx1;
  logic [NCH-1:0] irqStat;
  logic [NCH-1:0] irqMask;
  logic [15:0]    modeReg [NCH];
  logic [3:0]     syncReg [NCH];

  // channel state read back
  logic [AW-1:0]  srcA  [NCH];
  logic [AW-1:0]  dstA  [NCH];
  logic [15:0]    cntA  [NCH];
  logic [7:0]     frmA  [NCH];
  logic [NCH-1:0] chIrq;
  logic [NCH-1:0] chDone;

  // APB phase decode
  wire        access = psel & penable;
  wire        doIt   = access & pready;
  wire        wrEn   = doIt & pwrite;
  wire [15:0] wd     = pwdata[15:0];
  logic [15:0] rdWord;

  // channel window decode
  wire        inCh   = paddr >= `DIS_CH_BASE;
  wire [7:0]  chRel  = paddr - `DIS_CH_BASE;
  wire [2:0]  chNum  = chRel[7:`DIS_CH_SHIFT];
  wire [4:0]  chOfs  = chRel[`DIS_CH_SHIFT-1:0];
  wire        chOk   = inCh & (chNum < 3'(NCH)) &
                       (chOfs <= `DIS_CH_CNT) & (chOfs[1:0] == 2'b00);
  wire        glOk   = ~inCh & (paddr <= `DIS_OFS_MASK) &
                       (paddr[1:0] == 2'b00);
  wire        mapped = chOk | glOk;

  // write strobes for global registers
  wire wrPrio = wrEn & ~inCh & (paddr == `DIS_OFS_PRIO);
  wire wrE0   = wrEn & ~inCh & (paddr == `DIS_OFS_EIDX0);
  wire wrE1   = wrEn & ~inCh & (paddr == `DIS_OFS_EIDX1);
  wire wrF0   = wrEn & ~inCh & (paddr == `DIS_OFS_FIDX0);
  wire wrF1   = wrEn & ~inCh & (paddr == `DIS_OFS_FIDX1);
  wire wrStat = wrEn & ~inCh & (paddr == `DIS_OFS_STAT);
  wire wrMask = wrEn & ~inCh & (paddr == `DIS_OFS_MASK);

  // routing select field
  wire [1:0] route = prio[`DIS_PRIO_ROUTE_HI:`DIS_PRIO_ROUTE_LO];

  // APB answer: one wait state, then ready with data or error
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      prdata  <= (access & ~pready & ~pwrite) ? {16'h0000, rdWord}
                                              : '0;
    end
  end

  // read data selection
  always_comb begin
    rdWord = 16'h0000;
    if (chOk) begin
      case (chOfs)
        `DIS_CH_MODE: rdWord = modeReg[chNum];
        `DIS_CH_SYNC: rdWord = {syncReg[chNum], 4'h0, frmA[chNum]};
        `DIS_CH_SRC:  rdWord = 16'(srcA[chNum]);
        `DIS_CH_DST:  rdWord = 16'(dstA[chNum]);
        `DIS_CH_CNT:  rdWord = cntA[chNum];
        default:      rdWord = 16'h0000;
      endcase
    end else if (glOk) begin
      case (paddr)
        `DIS_OFS_PRIO:  rdWord = prio;
        `DIS_OFS_EIDX0: rdWord = 16'(elemIdx0);
        `DIS_OFS_EIDX1: rdWord = 16'(elemIdx1);
        `DIS_OFS_FIDX0: rdWord = 16'(frmIdx0);
        `DIS_OFS_FIDX1: rdWord = 16'(frmIdx1);
        `DIS_OFS_STAT:  rdWord = 16'(irqStat);
        `DIS_OFS_MASK:  rdWord = 16'(irqMask);
        default:        rdWord = 16'h0000;
      endcase
    end
  end

  // channel enables clear themselves when a block completes
  wire [NCH-1:0] next_enable =
    (wrPrio ? wd[NCH-1:0] : prio[NCH-1:0]) & ~chDone;

  // priority/enable register, routing resets to serial
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) prio <= `DIS_RST_WORD; // R12
    else prio <= {(wrPrio ? wd[15:NCH] : prio[15:NCH]), next_enable};
  end

  // index registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      elemIdx0 <= '0;
      elemIdx1 <= '0;
      frmIdx0  <= '0;
      frmIdx1  <= '0;
    end else begin
      if (wrE0) elemIdx0 <= wd[AW-1:0];
      if (wrE1) elemIdx1 <= wd[AW-1:0];
      if (wrF0) frmIdx0  <= wd[AW-1:0];
      if (wrF1) frmIdx1  <= wd[AW-1:0];
    end
  end

  // sticky status, write one to clear, a new event wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqStat <= '0;
      irqMask <= '0;
      irq     <= 1'b0;
    end else begin
      irqStat <= (irqStat & ~(wrStat ? wd[NCH-1:0] : '0)) | chIrq;
      if (wrMask) irqMask <= wd[NCH-1:0];
      irq <= |(irqStat & irqMask);
    end
  end

  // per-channel mode, sync selector and channel core
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gCh // R11
      wire hit = wrEn & chOk & (chNum == 3'(g));
      wire [3:0] wrSel = {hit & (chOfs == `DIS_CH_SYNC),
                          hit & (chOfs == `DIS_CH_CNT),
                          hit & (chOfs == `DIS_CH_DST),
                          hit & (chOfs == `DIS_CH_SRC)};
      dis_pkg::dis_mode_t mode;
      assign mode = {modeReg[g][`DIS_MODE_ABU],
                     modeReg[g][`DIS_MODE_INTERRUPT_MODE_BIT],
                     modeReg[g][`DIS_MODE_CHANNEL_INTERRUPT_ENABLE],
                     modeReg[g][`DIS_MODE_SRCSEL],  // R01
                     modeReg[g][`DIS_MODE_DSTSEL]}; // R01

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          modeReg[g] <= `DIS_RST_WORD;
          syncReg[g] <= `DIS_SYNC_NONE;
        end else begin
          if (hit && chOfs == `DIS_CH_MODE) modeReg[g] <= wd;
          if (wrSel[3])
            syncReg[g] <= wd[`DIS_SYNC_HI:`DIS_SYNC_LO]; // R08 R09 R10
        end
      end

      dis_channel #(.AW(AW)) uCh (
        .clk        (clk),
        .rstn       (rstn),
        .enable     (prio[g]),
        .mode       (mode),
        .syncSel    (syncReg[g]),
        .events     (syncEvents),
        .elemIdx0   (elemIdx0),
        .elemIdx1   (elemIdx1),
        .frmIdx0    (frmIdx0),
        .frmIdx1    (frmIdx1),
        .wrSel      (wrSel),
        .wdata      (wd),
        .srcAddr    (srcA[g]),
        .dstAddr    (dstA[g]),
        .elemCount  (cntA[g]),
        .frameCount (frmA[g]),
        .irqPulse   (chIrq[g]),
        .blockDone  (chDone[g])
      );
    end
  endgenerate

  // shared CPU lines; reserved code stays on serial sources
  dis_pkg::dis_port_irq_t next_shared;
  always_comb begin
    case (route)
      `DIS_ROUTE_PART: next_shared = {serialIrq.rx2, serialIrq.tx2,
                                      chIrq[2], chIrq[3]}; // R13
      `DIS_ROUTE_ALL:  next_shared = {chIrq[0], chIrq[1],
                                      chIrq[2], chIrq[3]}; // R13
      default:         next_shared = serialIrq; // R12 R16
    endcase
  end

  // registered interrupt outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cpuIrqShared <= '0;
      cpuIrqChan45 <= 2'b00;
    end else begin
      cpuIrqShared <= next_shared; // R11
      cpuIrqChan45 <= chIrq[5:4]; // R11
    end
  end

  a_route_serial: assert property (route != `DIS_ROUTE_PART // R16
    && route != `DIS_ROUTE_ALL |=> cpuIrqShared == $past(serialIrq))
    else $error("serial lines not on shared outputs");
  a_route_all: assert property (route == `DIS_ROUTE_ALL |=> // R13
    cpuIrqShared == {$past(chIrq[0]), $past(chIrq[1]),
                     $past(chIrq[2]), $past(chIrq[3])})
    else $error("channels 0-3 not routed");
  a_route_part: assert property (route == `DIS_ROUTE_PART |=> // R13
    cpuIrqShared.rx1 == $past(chIrq[2]) &&
    cpuIrqShared.tx2 == $past(serialIrq.tx2))
    else $error("partial routing wrong");
  a_route_reset: assert property ($rose(rstn) |-> route == 2'b00) // R12
    else $error("routing not serial after reset");

endmodule

// File: dis_map.svh
/*
  Register offsets, field positions and reset values of the DMA
  index, sync and interrupt block. Assumes a 32-bit APB with byte
  addresses; registers are 16 bits wide in the low half of a word.
*/
`ifndef DIS_MAP_SVH
`define DIS_MAP_SVH

// global registers
`define DIS_OFS_PRIO      8'h00
`define DIS_OFS_EIDX0     8'h04
`define DIS_OFS_EIDX1     8'h08
`define DIS_OFS_FIDX0     8'h0C
`define DIS_OFS_FIDX1     8'h10
`define DIS_OFS_STAT      8'h14
`define DIS_OFS_MASK      8'h18

// channel windows: base plus channel times stride
`define DIS_CH_BASE       8'h40
`define DIS_CH_SHIFT      5
`define DIS_CH_COUNT      6
`define DIS_CH_MODE       5'h00
`define DIS_CH_SYNC       5'h04
`define DIS_CH_SRC        5'h08
`define DIS_CH_DST        5'h0C
`define DIS_CH_CNT        5'h10

// field positions
`define DIS_PRIO_ROUTE_HI 7
`define DIS_PRIO_ROUTE_LO 6
`define DIS_MODE_ABU      12
`define DIS_MODE_INTERRUPT_MODE_BIT     11
`define DIS_MODE_CHANNEL_INTERRUPT_ENABLE     10
`define DIS_MODE_SRCSEL   1
`define DIS_MODE_DSTSEL   0
`define DIS_SYNC_HI       15
`define DIS_SYNC_LO       12

// routing codes and reset values
`define DIS_ROUTE_SERIAL  2'h0
`define DIS_ROUTE_PART    2'h1
`define DIS_ROUTE_ALL     2'h2
`define DIS_RST_WORD      16'h0000
`define DIS_SYNC_NONE     4'h0
`define DIS_SYNC_RSVD     4'hF

`endif

// File: dis_pkg.sv
/*
  Types shared by the DMA index, sync and interrupt block.
  Assumes dis_map.svh supplies the numeric constants.
*/
package dis_pkg;

  // serial port interrupts, or what replaces them on the shared lines
  typedef struct packed {
    logic rx2;
    logic tx2;
    logic rx1;
    logic tx1;
  } dis_port_irq_t;

  // decoded channel transfer mode control
  typedef struct packed {
    logic autobuffering_mode;
    logic interrupt_mode_bit;
    logic channel_interrupt_enable;
    logic srcSel;
    logic dstSel;
  } dis_mode_t;

endpackage

// File: dis_channel.sv
/*
  One DMA channel: address indexing, element and frame counting,
  sync event choice and interrupt pulse. Assumes events come from
  logic on the same clock and reset is already synchronised.
*/
`timescale 1ns/1ps
`include "dis_map.svh"
module dis_channel #(
  parameter int AW = 16
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              enable,
  input  wire dis_pkg::dis_mode_t mode,
  input  wire logic [3:0]        syncSel,
  input  wire logic [13:0]       events,
  input  wire logic [AW-1:0]     elemIdx0,
  input  wire logic [AW-1:0]     elemIdx1,
  input  wire logic [AW-1:0]     frmIdx0,
  input  wire logic [AW-1:0]     frmIdx1,
  input  wire logic [3:0]        wrSel,
  input  wire logic [15:0]       wdata,
  output logic [AW-1:0]          srcAddr,
  output logic [AW-1:0]          dstAddr,
  output logic [15:0]            elemCount,
  output logic [7:0]             frameCount,
  output logic                   irqPulse,
  output logic                   blockDone
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // event selected by the sync code; 0 free-runs, 15 never fires
  function automatic logic pickEvt(input logic [3:0] s,
                                   input logic [13:0] e);
    case (s)
      `DIS_SYNC_NONE: pickEvt = 1'b1;
      `DIS_SYNC_RSVD: pickEvt = 1'b0;
      default:        pickEvt = e[s - 4'h1];
    endcase
  endfunction

  logic [15:0] reload;
  wire         anyWr    = |wrSel;
  // a finished block stops the channel before its enable bit clears
  wire         step     = enable & ~blockDone & ~anyWr &
                          pickEvt(syncSel, events);
  wire         lastElem = (elemCount == 16'h0000); // R14
  wire         lastBlk  = lastElem & (frameCount == 8'h00);
  wire         halfHit  = ~lastElem &
                          ((elemCount - 16'h0001) == {1'b0, reload[15:1]});
  // index choice: element index mid-frame, frame index at the end
  wire [AW-1:0] srcStep = lastElem ? (mode.srcSel ? frmIdx1 : frmIdx0)
                                   : (mode.srcSel ? elemIdx1 : elemIdx0);
  wire [AW-1:0] dstStep = lastElem ? (mode.dstSel ? frmIdx1 : frmIdx0)
                                   : (mode.dstSel ? elemIdx1 : elemIdx0);
  wire irqHit = mode.channel_interrupt_enable & (mode.autobuffering_mode
                ? (lastElem | (mode.interrupt_mode_bit & halfHit))
                : (lastElem & (mode.interrupt_mode_bit | lastBlk)));

  // address update after each element transfer, software write wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      srcAddr <= '0;
      dstAddr <= '0;
    end else begin
      if (wrSel[0]) srcAddr <= wdata[AW-1:0];
      else if (step) srcAddr <= srcAddr + srcStep; // R01 R02 R03
      if (wrSel[1]) dstAddr <= wdata[AW-1:0];
      else if (step) dstAddr <= dstAddr + dstStep; // R01 R02 R03
    end
  end

  // element and frame counters
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      elemCount  <= `DIS_RST_WORD;
      reload     <= `DIS_RST_WORD;
      frameCount <= 8'h00;
    end else if (wrSel[2]) begin
      elemCount <= wdata;
      reload    <= wdata;
    end else if (wrSel[3]) begin
      frameCount <= wdata[7:0];
    end else if (step) begin
      if (!lastElem) elemCount <= elemCount - 16'h0001; // R14
      else elemCount <= reload;
      if (lastElem && !mode.autobuffering_mode && frameCount != 8'h00)
        frameCount <= frameCount - 8'h01; // R15
    end
  end

  // interrupt pulse and block completion
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqPulse  <= 1'b0;
      blockDone <= 1'b0;
    end else begin
      irqPulse  <= step & irqHit; // R04 R05 R06 R07
      blockDone <= step & lastBlk & ~mode.autobuffering_mode;
    end
  end

  a_elem_index: assert property (step && !lastElem |=> // R02
    srcAddr == $past(srcAddr) + $past(srcStep))
    else $error("source address missed element index");
  a_frame_index: assert property (step && lastElem |=> // R03
    dstAddr == $past(dstAddr) + $past(dstStep))
    else $error("destination missed frame index");
  a_elem_count: assert property (step && !lastElem |=> // R14
    elemCount == $past(elemCount) - 16'h0001)
    else $error("element counter did not decrement");
  a_frame_count: assert property (step && lastElem && !mode.autobuffering_mode // R15
    && frameCount != 8'h00 |=> frameCount == $past(frameCount) - 8'h01)
    else $error("frame counter did not decrement");
  a_irq_off: assert property (!mode.channel_interrupt_enable |=> !irqPulse) // R07
    else $error("interrupt while disabled");
  a_irq_block: assert property (step && !mode.autobuffering_mode && !mode.interrupt_mode_bit // R05
    && mode.channel_interrupt_enable |=> irqPulse == $past(lastBlk))
    else $error("block interrupt wrong");
  a_sync_none: assert property (enable && syncSel == `DIS_SYNC_NONE // R08
    && !anyWr && !blockDone |-> step)
    else $error("unsynchronised channel stalled");

endmodule

// File: dis_far_model.sv
/*
  Far side of the DMA index, sync and interrupt block: serial port and
  timer logic that pulses sync events and holds serial interrupts.
  Assumes the bench asks for one event at a time, on the same clock.
*/
`timescale 1ns/1ps
module dis_far_model (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   trigger,
  input  wire logic [3:0]             triggerSel,
  input  wire dis_pkg::dis_port_irq_t serialSet,
  output logic [13:0]                 syncEvents,
  output dis_pkg::dis_port_irq_t      serialIrq
);
  // one-cycle event pulse on the requested line, serial irqs as levels
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncEvents <= 14'h0000;
      serialIrq  <= 4'h0;
    end else begin
      syncEvents <= trigger ? (14'h0001 << triggerSel) : 14'h0000;
      serialIrq  <= serialSet;
    end
  end
endmodule

// File: tb_dis_dma_index_sync.sv
/*
  Self-checking bench for the DMA index, sync and interrupt block.
  Assumes the APB slave answers with one wait state and the far side
  model supplies sync events and serial port interrupts.
*/
`timescale 1ns/1ps
`include "dis_map.svh"
module tb_dis_dma_index_sync;
  logic                   clk, resetn, psel, penable, pwrite;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata, rdat;
  logic                   pready, pslverr, irq, rerr, trig;
  logic [13:0]            syncEvents;
  logic [3:0]             tsel;
  logic [1:0]             cpuIrqChan45, route;
  dis_pkg::dis_port_irq_t serialIrq, cpuIrqShared, serialSet;
  int                     miscompares, cmp_count, pulses;

  dis_dma_index_sync dut_u (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .syncEvents(syncEvents), .serialIrq(serialIrq),
    .cpuIrqShared(cpuIrqShared), .cpuIrqChan45(cpuIrqChan45));
  dis_far_model far_u (.clk(clk), .rstn(resetn), .trigger(trig),
    .triggerSel(tsel), .serialSet(serialSet), .syncEvents(syncEvents),
    .serialIrq(serialIrq));

  // clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // counts channel interrupt pulses reaching the cpu lines
  always @(posedge clk) begin
    if (resetn && (|cpuIrqShared || |cpuIrqChan45)) pulses <= pulses + 1;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) chk(1'b0, 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask

  task automatic fire(input int b);
    @(posedge clk);
    trig <= 1'b1;
    tsel <= 4'(b);
    @(posedge clk);
    trig <= 1'b0;
  endtask

  // program a channel, pace it by nev events and count irq pulses
  task automatic run(input int ch, input logic [15:0] md,
                     input logic [15:0] syn, input logic [15:0] cnt,
                     input int nev, input int bitI, input int expP);
    logic [7:0] base;
    int         p0;
    base = 8'(`DIS_CH_BASE + (ch << `DIS_CH_SHIFT));
    wr(base + `DIS_CH_MODE, {16'h0000, md});
    wr(base + `DIS_CH_SYNC, {16'h0000, syn});
    wr(base + `DIS_CH_CNT, {16'h0000, cnt});
    wr(`DIS_OFS_PRIO, {24'h000000, route, 6'(1 << ch)});
    p0 = pulses;
    repeat (nev) fire(bitI);
    repeat (6) @(posedge clk);
    chk(32'(pulses - p0), 32'(expP));
  endtask

  // watchdog
  initial begin
    #(20000 * 50);
    miscompares++;
    $display("BAD t=%0t watchdog expired", $time);
    conclude();
  end

  initial begin
    logic [3:0] routeExp [4];
    routeExp = '{4'hF, 4'hC, 4'h0, 4'hF};
    {resetn, psel, penable, pwrite, trig} = 5'b00000;
    {paddr, pwdata, tsel, route} = '0;
    serialSet = 4'hF;
    miscompares = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(`DIS_OFS_PRIO, 32'h0000_0000);
    chk(cpuIrqShared, 4'hF);
    apb(1'b0, 8'h1C, 32'h0);
    chk(rerr, 1'b1);
    // routing table with all serial interrupts raised
    for (int r = 0; r < 4; r++) begin
      wr(`DIS_OFS_PRIO, 32'(r << `DIS_PRIO_ROUTE_LO));
      repeat (3) @(posedge clk);
      chk(cpuIrqShared, routeExp[r]);
    end
    serialSet <= 4'h0;
    route = `DIS_ROUTE_ALL;
    // index sets: source uses set one, destination set zero
    wr(`DIS_OFS_EIDX0, 32'h3);
    wr(`DIS_OFS_EIDX1, 32'h5);
    wr(`DIS_OFS_FIDX0, 32'h10);
    wr(`DIS_OFS_FIDX1, 32'h20);
    wr(8'h40 + `DIS_CH_MODE, 32'h0402);
    wr(8'h40 + `DIS_CH_SRC, 32'h100);
    wr(8'h40 + `DIS_CH_DST, 32'h200);
    run(0, 16'h0402, 16'h0000, 16'h1, 0, 0, 1);
    rdchk(8'h40 + `DIS_CH_SRC, 32'h125);
    rdchk(8'h40 + `DIS_CH_DST, 32'h213);
    rdchk(8'h40 + `DIS_CH_CNT, 32'h1);
    rdchk(`DIS_OFS_PRIO, 32'h80);
    // multiframe, three frames, paced by port1 receive on ch1 and ch4
    for (int ch = 1; ch < 5; ch += 3) begin
      run(ch, 16'h0C00, 16'h5002, 16'h0, 3, 4, 3);
      run(ch, 16'h0400, 16'h5002, 16'h0, 3, 4, 1);
      run(ch, 16'h0800, 16'h5002, 16'h0, 3, 4, 0);
      rdchk(`DIS_OFS_PRIO, 32'h80);
    end
    // autobuffer, four elements, paced by the timer
    run(3, 16'h1C00, 16'hD000, 16'h3, 4, 12, 2);
    run(3, 16'h1400, 16'hD000, 16'h3, 4, 12, 1);
    run(3, 16'h1800, 16'hD000, 16'h3, 4, 12, 0);
    // sync codes 1 to 14: a wrong event first, then the chosen one; reserved 15 gets two wrong ones
    wr(8'h80 + `DIS_CH_MODE, 32'h0);
    wr(`DIS_OFS_PRIO, 32'h80);
    for (int c = 1; c < 16; c++) begin
      wr(8'h80 + `DIS_CH_SYNC, 32'(c << `DIS_SYNC_LO));
      // enable only once a paced code is in place
      if (c == 1) wr(`DIS_OFS_PRIO, 32'h84);
      wr(8'h80 + `DIS_CH_CNT, 32'h5);
      fire(c == 1 ? 13 : c - 2);
      fire(c == 15 ? 0 : c - 1);
      rdchk(8'h80 + `DIS_CH_CNT, c == 15 ? 32'h5 : 32'h4);
    end
    // sticky status, mask and write-one clear
    rdchk(`DIS_OFS_STAT, 32'h1B);
    chk(irq, 1'b0);
    wr(`DIS_OFS_MASK, 32'h08);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    wr(`DIS_OFS_STAT, 32'h3F);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    rdchk(`DIS_OFS_STAT, 32'h0);
    conclude();
  end
endmodule
